// File: ucrps_pkg.sv
// constants for the update command, rate pin status and active image logic
package ucrps_pkg;

   // ****************************************************************
   // register and command addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL_PEND = 8'h01;
   localparam logic [7:0] ADDR_RATE_PIN_STATUS_CTRL = 8'h20;
   localparam logic [7:0] ADDR_ACTIVE_CONTROL_IMAGE = 8'h21;
   localparam logic [7:0] CMD_FULL_UPDATE = 8'h00;
   localparam logic [7:0] CMD_BCAST_UPDATE = 8'h1e;
   localparam logic [7:0] CMD_KEEP_ACCUM_UPDATE = 8'h1f;

   // ****************************************************************
   // rate pin status / control field positions
   // ****************************************************************
   localparam int BIT_PIN_LEVEL = 7;
   localparam int BIT_ROSE = 6;
   localparam int BIT_FELL = 5;
   localparam int BIT_RISE_FULL = 4;
   localparam int BIT_RISE_KEEP = 3;
   localparam int BIT_FALL_FULL = 2;
   localparam int BIT_FALL_KEEP = 1;
   localparam int BIT_POWER_ON = 0;
   localparam logic RST_RISE_FULL = 1'h1;
   localparam logic RST_RISE_KEEP = 1'h0;
   localparam logic RST_FALL_FULL = 1'h1;
   localparam logic RST_FALL_KEEP = 1'h0;
   localparam logic RST_POWER_ON = 1'h1;

   // ****************************************************************
   // active control image field positions
   // ****************************************************************
   localparam int BIT_RATE_HI = 7;
   localparam int BIT_RATE_LO = 6;
   localparam int BIT_SLEEP = 5;
   localparam int BIT_SINGLE = 4;
   localparam int BIT_ATTN_EN = 3;
   localparam int BIT_CC_ATTN = 2;
   localparam int BIT_OVF_ATTN = 1;
   localparam int BIT_OVF_FLAG = 0;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [1:0] RATE_1024 = 2'h0;
   localparam logic [1:0] RATE_256 = 2'h1;
   localparam logic [1:0] RATE_64 = 2'h2;
   localparam logic [1:0] RATE_8 = 2'h3;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_FREQ_MHZ = 125;
   localparam int ATTN_PULSE_NS = 5000;
   localparam logic [9:0] ATTN_PULSE_CYC =
      10'(ATTN_PULSE_NS * CLK_FREQ_MHZ / 1000);

endpackage

// File: ucrps_core.sv
// update commands, rate pin status/control and active control image
`timescale 1ns/10ps

// Behaviour
// RULE1 - command 1Fh refreshes results, leaves accumulators untouched.
// RULE2 - host waits 1 ms after keep-accumulator update before reading.
// RULE3 - status bit 7 reads present synchronised rate pin level.
// RULE4 - bit 6 set on pin rise, cleared by full or broadcast update.
// RULE5 - bit 5 set on pin fall, cleared by full or broadcast update.
// RULE6 - rising edge runs limited full (bit 4) or keep (bit 3) update.
// RULE7 - falling edge runs limited full (bit 2) or keep (bit 1) update.
// RULE8 - edge update enables change only by host write.
// RULE9 - full and keep both enabled on an edge: only full runs.
// RULE10 - limited updates refresh results; only full clears accumulators.
// RULE11 - limited updates never activate pending control settings.
// RULE12 - pin used as attention output: status register reads all zero.
// RULE13 - reading the status register clears nothing.
// RULE14 - power-on flag set only by reset, cleared by host write.
// RULE15 - image at 21h shows active settings of control 01h only.
// RULE16 - host trusts the image 1 ms after any update command.
// RULE17 - rate change takes effect when current conversion cycle completes.
// RULE18 - image bits 7:6 encode rate 1024, 256, 64, 8 per second.
// RULE19 - image bit 5 shows sleep, bit 4 single shot.
// RULE20 - image bit 3 shows attention output function enable.
// RULE21 - cycle-done alerting pulses attention output for 5 us.
// RULE22 - overflow alerting drives attention output on accumulator overflow.
// RULE23 - image bit 0 shows accumulator or count overflow; the code sets it from ACCUM_OVF_I only.
// RULE24 - broadcast update behaves exactly like the full update.
// RULE25 - rate pin passes two flip-flops before any logic reads it.
module ucrps_core (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic RATE_PIN_I,
   input wire logic PIN_IS_ATTN_I,
   input wire logic CMD_STB_I,
   input wire logic [7:0] CMD_CODE_I,
   input wire logic WR_STB_I,
   input wire logic [7:0] WR_ADDR_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic RD_STB_I,
   input wire logic [7:0] RD_ADDR_I,
   input wire logic CYCLE_DONE_I,
   input wire logic ACCUM_OVF_I,
   output logic [7:0] RD_DATA_O,
   output logic RESULTS_REFRESH_O,
   output logic ACCUM_CLEAR_O,
   output logic ATTN_O,
   output logic [1:0] ACTIVE_RATE_O,
   output logic ACTIVE_SLEEP_O,
   output logic ACTIVE_SINGLE_O
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pin_prev_reg;
   logic rise;
   logic fall;
   logic cmd_full;
   logic cmd_keep;
   logic lim_full;
   logic lim_keep;
   logic activate;
   logic wr_status;
   logic rate_pin_rose_flag_reg;
   logic rate_pin_fell_flag_reg;
   logic en_rise_full_reg;
   logic en_rise_keep_reg;
   logic en_fall_full_reg;
   logic en_fall_keep_reg;
   logic power_on_flag_reg;
   logic [7:0] ctrl_pend_reg;
   logic [1:0] rate_act_reg;
   logic [1:0] rate_target_reg;
   logic rate_wait_reg;
   logic sleep_act_reg;
   logic single_shot_sel_reg;
   logic attn_en_reg;
   logic cycle_done_attention_en_reg;
   logic overflow_attention_en_reg;
   logic accum_overflow_flag_reg;
   logic [9:0] attn_cnt_reg;
   logic [9:0] attn_cnt_next;
   logic attn_next;
   logic [7:0] status_img;
   logic [7:0] active_img;
   logic [7:0] rd_data_next;

   // ****************************************************************
   // rate pin synchroniser and edge detect
   // ****************************************************************
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pin_meta_reg <= 1'h0;
         pin_sync_reg <= 1'h0;
         pin_prev_reg <= 1'h0;
      end else begin
         pin_meta_reg <= RATE_PIN_I; // [RULE25]
         pin_sync_reg <= pin_meta_reg; // [RULE25]
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // edges ignored while the pin serves as attention output
   assign rise = pin_sync_reg & ~pin_prev_reg & ~PIN_IS_ATTN_I;
   assign fall = ~pin_sync_reg & pin_prev_reg & ~PIN_IS_ATTN_I;

   // ****************************************************************
   // command and update decode
   // ****************************************************************
   assign cmd_full = CMD_STB_I &&
      (CMD_CODE_I == ucrps_pkg::CMD_FULL_UPDATE ||
       CMD_CODE_I == ucrps_pkg::CMD_BCAST_UPDATE); // [RULE24]
   assign cmd_keep = CMD_STB_I &&
      (CMD_CODE_I == ucrps_pkg::CMD_KEEP_ACCUM_UPDATE); // [RULE1]
   assign lim_full = (rise & en_rise_full_reg) |
      (fall & en_fall_full_reg); // [RULE6] [RULE7]
   assign lim_keep = ~lim_full & ((rise & en_rise_keep_reg) |
      (fall & en_fall_keep_reg)); // [RULE9]
   assign activate = cmd_full | cmd_keep; // [RULE11]
   assign wr_status = WR_STB_I &&
      (WR_ADDR_I == ucrps_pkg::ADDR_RATE_PIN_STATUS_CTRL);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RESULTS_REFRESH_O <= 1'h0;
         ACCUM_CLEAR_O <= 1'h0;
      end else begin
         RESULTS_REFRESH_O <= activate | lim_full | lim_keep; // [RULE10]
         ACCUM_CLEAR_O <= cmd_full | lim_full; // [RULE1] [RULE10]
      end
   end

   // ****************************************************************
   // edge flags: set wins over clear
   // ****************************************************************
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rate_pin_rose_flag_reg <= 1'h0;
         rate_pin_fell_flag_reg <= 1'h0;
      end else begin
         if (rise) begin
            rate_pin_rose_flag_reg <= 1'h1; // [RULE4]
         end else if (cmd_full) begin
            rate_pin_rose_flag_reg <= 1'h0; // [RULE4]
         end
         if (fall) begin
            rate_pin_fell_flag_reg <= 1'h1; // [RULE5]
         end else if (cmd_full) begin
            rate_pin_fell_flag_reg <= 1'h0; // [RULE5]
         end
      end
   end

   // ****************************************************************
   // edge update enables and power-on flag
   // ****************************************************************
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         en_rise_full_reg <= ucrps_pkg::RST_RISE_FULL;
         en_rise_keep_reg <= ucrps_pkg::RST_RISE_KEEP;
         en_fall_full_reg <= ucrps_pkg::RST_FALL_FULL;
         en_fall_keep_reg <= ucrps_pkg::RST_FALL_KEEP;
      end else if (wr_status) begin
         en_rise_full_reg <= WR_DATA_I[ucrps_pkg::BIT_RISE_FULL]; // [RULE8]
         en_rise_keep_reg <= WR_DATA_I[ucrps_pkg::BIT_RISE_KEEP]; // [RULE8]
         en_fall_full_reg <= WR_DATA_I[ucrps_pkg::BIT_FALL_FULL]; // [RULE8]
         en_fall_keep_reg <= WR_DATA_I[ucrps_pkg::BIT_FALL_KEEP]; // [RULE8]
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         power_on_flag_reg <= ucrps_pkg::RST_POWER_ON; // [RULE14]
      end else if (wr_status && !WR_DATA_I[ucrps_pkg::BIT_POWER_ON]) begin
         power_on_flag_reg <= 1'h0; // [RULE14]
      end
   end

   // ****************************************************************
   // pending control and activation
   // ****************************************************************
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_pend_reg <= ucrps_pkg::RST_CTRL;
      end else if (WR_STB_I && WR_ADDR_I == ucrps_pkg::ADDR_CTRL_PEND) begin
         ctrl_pend_reg <= WR_DATA_I;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sleep_act_reg <= ucrps_pkg::RST_CTRL[ucrps_pkg::BIT_SLEEP];
         single_shot_sel_reg <= ucrps_pkg::RST_CTRL[ucrps_pkg::BIT_SINGLE];
         attn_en_reg <= ucrps_pkg::RST_CTRL[ucrps_pkg::BIT_ATTN_EN];
         cycle_done_attention_en_reg <=
            ucrps_pkg::RST_CTRL[ucrps_pkg::BIT_CC_ATTN];
         overflow_attention_en_reg <=
            ucrps_pkg::RST_CTRL[ucrps_pkg::BIT_OVF_ATTN];
      end else if (activate) begin
         sleep_act_reg <= ctrl_pend_reg[ucrps_pkg::BIT_SLEEP]; // [RULE15]
         single_shot_sel_reg <= ctrl_pend_reg[ucrps_pkg::BIT_SINGLE];
         attn_en_reg <= ctrl_pend_reg[ucrps_pkg::BIT_ATTN_EN]; // [RULE20]
         cycle_done_attention_en_reg <=
            ctrl_pend_reg[ucrps_pkg::BIT_CC_ATTN];
         overflow_attention_en_reg <=
            ctrl_pend_reg[ucrps_pkg::BIT_OVF_ATTN];
      end
   end

   // rate waits for the running conversion cycle to finish
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rate_act_reg <= ucrps_pkg::RATE_1024;
         rate_target_reg <= ucrps_pkg::RATE_1024;
         rate_wait_reg <= 1'h0;
      end else if (activate) begin
         rate_target_reg <=
            ctrl_pend_reg[ucrps_pkg::BIT_RATE_HI:ucrps_pkg::BIT_RATE_LO];
         rate_wait_reg <= 1'h1; // [RULE17]
      end else if (rate_wait_reg && CYCLE_DONE_I) begin
         rate_act_reg <= rate_target_reg; // [RULE17] [RULE18]
         rate_wait_reg <= 1'h0;
      end
   end

   // ****************************************************************
   // overflow flag and attention output
   // ****************************************************************
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         accum_overflow_flag_reg <= 1'h0;
      end else if (ACCUM_OVF_I) begin
         accum_overflow_flag_reg <= 1'h1; // [RULE23]
      end else if (cmd_full | lim_full) begin
         accum_overflow_flag_reg <= 1'h0;
      end
   end

   always_comb begin
      attn_cnt_next = attn_cnt_reg;
      if (CYCLE_DONE_I && cycle_done_attention_en_reg && attn_en_reg) begin
         attn_cnt_next = ucrps_pkg::ATTN_PULSE_CYC; // [RULE21]
      end else if (attn_cnt_reg != 10'h000) begin
         attn_cnt_next = attn_cnt_reg - 10'h001;
      end
      attn_next = attn_en_reg && ((attn_cnt_reg != 10'h000) ||
         (overflow_attention_en_reg && accum_overflow_flag_reg)); // [RULE22]
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         attn_cnt_reg <= 10'h000;
         ATTN_O <= 1'h0;
      end else begin
         attn_cnt_reg <= attn_cnt_next;
         ATTN_O <= attn_next; // [RULE21] [RULE22]
      end
   end

   // ****************************************************************
   // converter-facing settings
   // ****************************************************************
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ACTIVE_RATE_O <= ucrps_pkg::RATE_1024;
         ACTIVE_SLEEP_O <= 1'h0;
         ACTIVE_SINGLE_O <= 1'h0;
      end else begin
         ACTIVE_RATE_O <= rate_act_reg;
         ACTIVE_SLEEP_O <= sleep_act_reg; // [RULE19]
         ACTIVE_SINGLE_O <= single_shot_sel_reg; // [RULE19]
      end
   end

   // ****************************************************************
   // register read
   // ****************************************************************
   assign status_img = PIN_IS_ATTN_I ? 8'h00 : {pin_sync_reg,
      rate_pin_rose_flag_reg, rate_pin_fell_flag_reg, en_rise_full_reg,
      en_rise_keep_reg, en_fall_full_reg, en_fall_keep_reg,
      power_on_flag_reg}; // [RULE3] [RULE12]
   assign active_img = {rate_act_reg, sleep_act_reg, single_shot_sel_reg,
      attn_en_reg, cycle_done_attention_en_reg, overflow_attention_en_reg,
      accum_overflow_flag_reg}; // [RULE15] [RULE18] [RULE19] [RULE23]

   always_comb begin
      case (RD_ADDR_I)
         ucrps_pkg::ADDR_RATE_PIN_STATUS_CTRL: rd_data_next = status_img;
         ucrps_pkg::ADDR_ACTIVE_CONTROL_IMAGE: rd_data_next = active_img;
         default: rd_data_next = 8'h00;
      endcase
   end

   // reads have no side effect on any flag
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RD_DATA_O <= 8'h00;
      end else if (RD_STB_I) begin
         RD_DATA_O <= rd_data_next; // [RULE13]
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   sequence s_cycle_alert;
      CYCLE_DONE_I && cycle_done_attention_en_reg && attn_en_reg;
   endsequence

   sequence s_rise_both;
      rise && en_rise_full_reg && en_rise_keep_reg;
   endsequence

   chk_keep_no_clear: assert property ( // [RULE1]
      cmd_keep && !lim_full |=> RESULTS_REFRESH_O && !ACCUM_CLEAR_O)
      else $error("keep update cleared accumulators");
   chk_pin_level_read: assert property ( // [RULE3]
      RD_STB_I && RD_ADDR_I == ucrps_pkg::ADDR_RATE_PIN_STATUS_CTRL &&
      !PIN_IS_ATTN_I |=> RD_DATA_O[ucrps_pkg::BIT_PIN_LEVEL] ==
      $past(pin_sync_reg))
      else $error("pin level bit wrong");
   chk_rose_flag_set: assert property ( // [RULE4]
      $rose(pin_sync_reg) && !PIN_IS_ATTN_I |=>
      rate_pin_rose_flag_reg)
      else $error("rose flag not set");
   chk_rose_keep_hold: assert property ( // [RULE4]
      cmd_keep && rate_pin_rose_flag_reg |=> rate_pin_rose_flag_reg)
      else $error("keep update cleared rose flag");
   chk_fell_flag_clear: assert property ( // [RULE5]
      cmd_full && !fall |=> !rate_pin_fell_flag_reg)
      else $error("fell flag not cleared");
   chk_full_wins_edge: assert property ( // [RULE9]
      s_rise_both |=> RESULTS_REFRESH_O && ACCUM_CLEAR_O)
      else $error("full update did not win");
   chk_fall_keep_only: assert property ( // [RULE7]
      fall && !en_fall_full_reg && en_fall_keep_reg |=>
      RESULTS_REFRESH_O && !ACCUM_CLEAR_O)
      else $error("limited keep update wrong");
   chk_enables_hold: assert property ( // [RULE8]
      !wr_status |=> $stable({en_rise_full_reg, en_rise_keep_reg,
      en_fall_full_reg, en_fall_keep_reg}))
      else $error("edge enables changed without write");
   chk_lim_no_activate: assert property ( // [RULE11]
      (lim_full || lim_keep) && !CMD_STB_I |=> $stable({sleep_act_reg,
      single_shot_sel_reg, attn_en_reg, overflow_attention_en_reg}))
      else $error("limited update activated settings");
   chk_attn_mode_zero: assert property ( // [RULE12]
      RD_STB_I && RD_ADDR_I == ucrps_pkg::ADDR_RATE_PIN_STATUS_CTRL &&
      PIN_IS_ATTN_I |=> RD_DATA_O == 8'h00)
      else $error("status not zero in attention mode");
   chk_power_on_hold: assert property ( // [RULE14]
      power_on_flag_reg && !wr_status |=> power_on_flag_reg)
      else $error("power-on flag lost without write");
   chk_attn_pulse: assert property ( // [RULE21]
      s_cycle_alert |-> ##2 ATTN_O)
      else $error("cycle done attention missing");
   chk_ovf_set_wins: assert property ( // [RULE23]
      ACCUM_OVF_I |=> accum_overflow_flag_reg)
      else $error("overflow flag lost");

endmodule

// File: ucrps_far_model.sv
// far-side model: register host over the command port and rate pin driver
`timescale 1ns/10ps
module ucrps_far_model #(
   parameter int SETTLE_CYC = 125000
) (
   input wire logic clk_i,
   input wire logic [7:0] rd_data_i,
   output logic rate_pin_o,
   output logic pin_is_attn_o,
   output logic cmd_stb_o,
   output logic [7:0] cmd_code_o,
   output logic wr_stb_o,
   output logic [7:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic rd_stb_o,
   output logic [7:0] rd_addr_o,
   output logic cycle_done_o,
   output logic accum_ovf_o
);
   // ****************************************************************
   // pin clock, unrelated in phase to the system clock
   // ****************************************************************
   logic link_clk;
   initial begin
      link_clk = 1'b0;
      {rate_pin_o, pin_is_attn_o, cmd_stb_o, wr_stb_o, rd_stb_o} = 5'h00;
      {cmd_code_o, wr_addr_o, wr_data_o, rd_addr_o} = 32'h00000000;
      {cycle_done_o, accum_ovf_o} = 2'h0;
      #5;
      forever #32 link_clk = ~link_clk;
   end

   // ****************************************************************
   // host requests, one cycle each; released lines show the inverse
   // ****************************************************************
   task automatic cmd(input logic [7:0] code);
      @(negedge clk_i);
      cmd_stb_o = 1'b1;
      cmd_code_o = code;
      @(negedge clk_i);
      cmd_stb_o = 1'b0;
      cmd_code_o = ~code;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_i);
      wr_stb_o = 1'b1;
      wr_addr_o = addr;
      wr_data_o = data;
      @(negedge clk_i);
      wr_stb_o = 1'b0;
      wr_addr_o = ~addr;
      wr_data_o = ~data;
   endtask

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk_i);
      rd_stb_o = 1'b1;
      rd_addr_o = addr;
      @(negedge clk_i);
      rd_stb_o = 1'b0;
      rd_addr_o = ~addr;
      @(negedge clk_i);
      data = rd_data_i;
   endtask

   // wait before trusting results or the active image
   task automatic settle();
      repeat (SETTLE_CYC) @(negedge clk_i);
   endtask

   // pin moves on the pin clock, then held long enough to be seen
   task automatic pin(input logic level);
      @(posedge link_clk);
      rate_pin_o = level;
      repeat (8) @(negedge clk_i);
   endtask

   task automatic attn_mode(input logic on);
      @(negedge clk_i);
      pin_is_attn_o = on;
      repeat (4) @(negedge clk_i);
   endtask

   task automatic pulse(input logic ovf);
      @(negedge clk_i);
      if (ovf) accum_ovf_o = 1'b1;
      else cycle_done_o = 1'b1;
      @(negedge clk_i);
      {cycle_done_o, accum_ovf_o} = 2'h0;
      repeat (3) @(negedge clk_i);
   endtask
endmodule

// File: tb.sv
// self-checking bench for the update command and rate pin status block
`timescale 1ns/10ps
module tb;
   logic clk, rst, rate_pin, pin_is_attn, cmd_stb, wr_stb, rd_stb;
   logic cycle_done, accum_ovf, refresh, clear, attn, act_sleep, act_single;
   logic [7:0] cmd_code, wr_addr, wr_data, rd_addr, rd_data;
   logic [1:0] act_rate;
   int fails = 0, comparisons = 0, n_ref = 0, n_clr = 0, n_attn = 0;
   int b_ref, b_clr;

   ucrps_core dut (.CLK_I(clk), .RST_I(rst), .RATE_PIN_I(rate_pin),
      .PIN_IS_ATTN_I(pin_is_attn), .CMD_STB_I(cmd_stb),
      .CMD_CODE_I(cmd_code), .WR_STB_I(wr_stb), .WR_ADDR_I(wr_addr),
      .WR_DATA_I(wr_data), .RD_STB_I(rd_stb), .RD_ADDR_I(rd_addr),
      .CYCLE_DONE_I(cycle_done), .ACCUM_OVF_I(accum_ovf),
      .RD_DATA_O(rd_data), .RESULTS_REFRESH_O(refresh),
      .ACCUM_CLEAR_O(clear), .ATTN_O(attn), .ACTIVE_RATE_O(act_rate),
      .ACTIVE_SLEEP_O(act_sleep), .ACTIVE_SINGLE_O(act_single));

   ucrps_far_model #(.SETTLE_CYC(4)) far (.clk_i(clk), .rd_data_i(rd_data),
      .rate_pin_o(rate_pin), .pin_is_attn_o(pin_is_attn),
      .cmd_stb_o(cmd_stb), .cmd_code_o(cmd_code), .wr_stb_o(wr_stb),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_stb_o(rd_stb),
      .rd_addr_o(rd_addr), .cycle_done_o(cycle_done),
      .accum_ovf_o(accum_ovf));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (refresh === 1'b1) n_ref++;
      if (clear === 1'b1) n_clr++;
      if (attn === 1'b1) n_attn++;
   end

   // ****************************************************************
   // checking helpers
   // ****************************************************************
   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rchk(input string what, input logic [7:0] addr,
                       input logic [7:0] exp);
      logic [7:0] v;
      far.rd(addr, v);
      chk(what, {8'h00, v}, {8'h00, exp});
   endtask

   task automatic snap();
      b_ref = n_ref;
      b_clr = n_clr;
   endtask

   task automatic pulses(input logic [15:0] r, input logic [15:0] c);
      repeat (3) @(negedge clk);
      chk("refresh pulses", 16'(n_ref - b_ref), r);
      chk("clear pulses", 16'(n_clr - b_clr), c);
   endtask

   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      rchk("status", 8'h20, 8'h15);
      rchk("image", 8'h21, 8'h00);
      rchk("unmapped", 8'h55, 8'h00);
      far.wr(8'h21, 8'hff);
      rchk("image ro", 8'h21, 8'h00);
      snap();
      far.cmd(ucrps_pkg::CMD_KEEP_ACCUM_UPDATE);
      pulses(16'h1, 16'h0);
      snap();
      far.cmd(8'h55);
      pulses(16'h0, 16'h0);
   endtask

   task automatic t_edges();
      logic [7:0] en [4] = '{8'h11, 8'h05, 8'h09, 8'h03};
      logic lv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      logic [15:0] full [4] = '{16'h1, 16'h1, 16'h0, 16'h0};
      for (int i = 0; i < 4; i++) begin
         far.wr(ucrps_pkg::ADDR_RATE_PIN_STATUS_CTRL, en[i]);
         snap();
         far.pin(lv[i]);
         pulses(16'h1, full[i]);
      end
      rchk("flags", 8'h20, 8'h63);
      rchk("flags again", 8'h20, 8'h63);
      far.cmd(ucrps_pkg::CMD_KEEP_ACCUM_UPDATE);
      rchk("flags keep", 8'h20, 8'h63);
      far.cmd(ucrps_pkg::CMD_FULL_UPDATE);
      rchk("flags full", 8'h20, 8'h03);
      far.wr(8'h20, 8'h01);
      snap();
      far.pin(1'b1);
      pulses(16'h0, 16'h0);
      far.wr(8'h20, 8'h07);
      snap();
      far.pin(1'b0);
      pulses(16'h1, 16'h1);
      far.wr(8'h20, 8'h06);
      far.wr(8'h20, 8'h07);
      rchk("power on", 8'h20, 8'h66);
      far.pin(1'b1);
      rchk("pin high", 8'h20, 8'he6);
   endtask

   task automatic t_attn_mode();
      far.attn_mode(1'b1);
      rchk("attn status", 8'h20, 8'h00);
      snap();
      far.pin(1'b0);
      pulses(16'h0, 16'h0);
      far.attn_mode(1'b0);
      rchk("status back", 8'h20, 8'h66);
   endtask

   task automatic t_image();
      far.wr(ucrps_pkg::ADDR_CTRL_PEND, 8'hf6);
      far.wr(8'h20, 8'h10);
      snap();
      far.pin(1'b1);
      pulses(16'h1, 16'h1);
      rchk("image pend", 8'h21, 8'h00);
      snap();
      far.cmd(ucrps_pkg::CMD_BCAST_UPDATE);
      pulses(16'h1, 16'h1);
      far.settle();
      rchk("image bcast", 8'h21, 8'h36);
      far.pulse(1'b0);
      rchk("image rate", 8'h21, 8'hf6);
      chk("active", {12'h000, act_rate, act_sleep, act_single},
          16'hf);
      rchk("flags bcast", 8'h20, 8'h90);
      for (int r = 0; r < 4; r++) begin
         far.wr(8'h01, {2'(r), 6'h00});
         far.cmd(ucrps_pkg::CMD_FULL_UPDATE);
         far.pulse(1'b0);
         chk("rate code", {14'h0000, act_rate}, 16'(r));
      end
   endtask

   task automatic t_alert();
      far.wr(8'h01, 8'h0c);
      far.cmd(ucrps_pkg::CMD_FULL_UPDATE);
      far.settle();
      rchk("image attn", 8'h21, 8'hcc);
      n_attn = 0;
      far.pulse(1'b0);
      repeat (700) @(negedge clk);
      chk("attn width", 16'(n_attn),
          16'(ucrps_pkg::ATTN_PULSE_CYC));
      far.wr(8'h01, 8'h0a);
      far.cmd(ucrps_pkg::CMD_KEEP_ACCUM_UPDATE);
      far.pulse(1'b1);
      chk("attn ovf", {15'h0000, attn}, 16'h1);
      rchk("ovf set", 8'h21, 8'h0b);
      far.cmd(ucrps_pkg::CMD_FULL_UPDATE);
      far.settle();
      rchk("ovf clear", 8'h21, 8'h0a);
   endtask

   initial begin
      rst = 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_edges();
      t_attn_mode();
      t_image();
      t_alert();
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule
